// *** core/adc_sequencer_control.sv ***
`timescale 1ns/100ps
// Behaviour
// R01 - Input at top rail gives FFh, no overflow
// R02 - Input at bottom rail gives 00h
// R03 - Load then convert phases repeat endlessly
// R04 - Eight approximation steps, capacitor isolated
// R05 - Twelve converter clocks, converter at half rate
// R06 - Setting on bit starts continuous conversions
// R07 - Done flag set per conversion, no request
// R08 - Result held until next conversion completes
// R09 - Control write while on restarts conversion
// R10 - Result read or control write clears done
// R11 - Four-bit channel field selects input n
// R12 - On bit read/write; clear stops converter
// R13 - Wait ignored, halt disables the converter
// R14 - Result register read-only unsigned byte
// R15 - Software sets analog pins as plain inputs
// R16 - Switch-off aborts, result keeps last value
module adc_sequencer_control
  import adc_seq_pkg::*;
#(
  parameter int STEPS = SAR_STEPS
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Power mode inputs from the clock controller
  input  wire logic        haltMode,
  input  wire logic        waitMode,
  // Comparator: high when sampled input is at or above the trial code
  input  wire logic        compareHigh,
  // Analog front end control
  output afe_ctrl_t        afeCtrl,
  output logic             irq
);

  // Always ready: every access completes in its first access cycle
  assign pready = 1'b1;

  // Bus decode
  // Offsets are word indices; the byte address is four times the index.
  // Only the low byte lane carries register data, so only pstrb[0] is
  // looked at; a write with that lane off to the control, status or mask register is ignored without an error.
  // Decode is purely combinational because pready is tied high and the
  // address is held for the whole access phase.
  wire        access     = psel && penable;
  wire        wrAccess   = access && pwrite;
  wire        rdAccess   = access && !pwrite;
  wire        hitResult  = (paddr == ADDR_RESULT);
  wire        hitCtrl    = (paddr == ADDR_CTRL);
  wire        hitIrqStat = (paddr == ADDR_IRQ_STATUS);
  wire        hitIrqMask = (paddr == ADDR_IRQ_MASK);
  wire        hitAny     = hitResult || hitCtrl || hitIrqStat || hitIrqMask;
  wire        lane0      = pstrb[0];
  // Result is read-only; a write to it is an error R14
  wire        badAccess  = !hitAny || (pwrite && hitResult);
  wire        ctrlWrite  = wrAccess && hitCtrl && lane0;
  wire        resultRead = rdAccess && hitResult;

  assign pslverr = access && badAccess;

  // Registers
  // All state sits in flip-flops with an asynchronous clear.
  // The on bit and channel field belong to software; the done flag and
  // the result belong to the hardware, and software only clears done.
  logic [7:0]        result;     // Last completed conversion
  logic              convOn;     // Converter-on bit
  logic [CHAN_W-1:0] chanSel;    // Channel select field
  logic              doneFlag;   // Conversion-done flag
  logic [1:0]        irqStatus;  // Sticky events
  logic [1:0]        irqMask;    // Event enables
  phase_t            phase;
  logic              adcTick;    // Converter clock enable, half of clk_sys
  logic [3:0]        periodCnt;  // Converter periods within the phase
  logic [7:0]        sarCode;    // Trial code being built
  logic [2:0]        bitIdx;     // Bit currently under trial

  // The converter is powered only while software has it on and the
  // clock controller is not in halt. Wait mode is deliberately unused:
  // the core keeps converting while the processor sleeps.
  // Halt stops the converter; wait mode has no effect R13
  wire running = convOn && !haltMode;

  // Converter clock enable: one pulse every second system clock R05
  // The enable restarts from zero whenever the converter stops, so the
  // first tick of a conversion started from off falls one system clock after start.
  // A free-running divider would save a gate but make the conversion
  // length depend on the phase of an unrelated counter.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      adcTick <= 1'b0;
    end else begin
      adcTick <= running ? !adcTick : 1'b0;
    end
  end

  // Phase end conditions, in converter periods
  // The load phase counts converter ticks; the approximation phase
  // counts down the bit under trial, so neither needs a wide counter.
  // Both phase ends are qualified by the tick to stay on the slow grid.
  wire loadEnd = adcTick && (phase == PH_LOAD) && (periodCnt == 4'(LOAD_PERIODS - 1));
  wire sarEnd  = adcTick && (phase == PH_SAR) && (bitIdx == 3'h0);
  // Restart on control write while on; abort on switch-off R06 R09 R16
  wire restart = ctrlWrite && pwdata[POS_ON];
  wire abortCv = (phase != PH_OFF) && (ctrlWrite || !running);

  // Final code: comparator decision folded into current trial bit
  // A low comparator answer drops the bit that is on trial; a high
  // answer keeps it. Inputs at the top rail keep every bit and inputs at
  // the bottom rail drop every bit, so no special rail logic is needed.
  wire [7:0] trialDone = compareHigh ? sarCode : (sarCode & ~(8'h01 << bitIdx));

  // Sequencer: load phase, then eight approximation steps, repeat R03
  // Timing of one conversion, counted in system clocks from the edge
  // that enters the load phase:
  //   edges 1 to 8   four converter ticks with the capacitor connected
  //   edges 9 to 24  eight ticks, one result bit per tick, MSB first
  // The last tick stores the result and sets the done flag, and the same
  // edge re-enters the load phase, so conversions run back to back.
  // A control write has priority over everything else in this block so
  // that a restart never mixes bits from two different samples.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase     <= PH_OFF;
      periodCnt <= 4'h0;
      sarCode   <= 8'h00;
      bitIdx    <= 3'h7;
    end else if (ctrlWrite) begin
      // Any control write drops the work in progress R09
      phase     <= (restart && !haltMode) ? PH_LOAD : PH_OFF;
      periodCnt <= 4'h0;
      sarCode   <= 8'h00;
      bitIdx    <= 3'h7;
    end else if (!running) begin
      // Off or halted: nothing runs; a halt that lands on the last tick still stores the result R12 R16
      phase     <= PH_OFF;
      periodCnt <= 4'h0;
      bitIdx    <= 3'h7;
    end else begin
      unique case (phase)
        PH_OFF: begin
          // Switched on by some path other than a control write
          phase <= PH_LOAD;
        end
        PH_LOAD: begin
          if (adcTick) begin
            periodCnt <= periodCnt + 4'h1;
          end
          if (loadEnd) begin
            phase   <= PH_SAR;                 // R04
            sarCode <= 8'h80;
            bitIdx  <= 3'h7;
          end
        end
        PH_SAR: begin
          if (adcTick) begin
            if (bitIdx == 3'h0) begin
              phase     <= PH_LOAD;            // R03
              periodCnt <= 4'h0;
            end else begin
              // Keep or drop tried bit, then try the next one R04
              sarCode <= trialDone | (8'h01 << (bitIdx - 3'h1));
              bitIdx  <= bitIdx - 3'h1;
            end
          end
        end
        default: begin
          // Unused code: fall back to the stopped state
          phase <= PH_OFF;
        end
      endcase
    end
  end

  // Result updates only at the end of a full conversion R08
  // Rail inputs give all-ones or all-zeros naturally R01 R02
  // Writes that hit the result register are refused on the bus and never
  // reach this flip-flop; a switch-off simply stops the update.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      result <= RESULT_RST;
    end else if (sarEnd && !ctrlWrite) begin
      result <= trialDone;                     // R08
    end
  end

  // Control fields; software owns on bit and channel R11 R12
  // Bits 6 and 4 are reserved: writes to them are dropped and they read 0.
  // Halt leaves the on bit alone, so conversions resume when halt drops.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      convOn  <= CTRL_RST[POS_ON];
      chanSel <= CTRL_RST[POS_CHAN +: CHAN_W];
    end else if (ctrlWrite) begin
      convOn  <= pwdata[POS_ON];               // R12
      chanSel <= pwdata[POS_CHAN +: CHAN_W];   // R11
    end
  end

  // Done flag: set at conversion end wins over a result-read clear R07 R10
  // A control write in the completion cycle aborts that conversion, so
  // its result is discarded and the flag stays clear. A result read in
  // the completion cycle loses to the set, so no completion is missed.
  wire setDone = sarEnd && !ctrlWrite;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      doneFlag <= CTRL_RST[POS_DONE];
    end else if (setDone) begin
      doneFlag <= 1'b1;                        // R07
    end else if (resultRead || ctrlWrite) begin
      doneFlag <= 1'b0;                        // R10
    end
  end

  // Sticky event bits, write one to clear, set beats clear
  // The converter core itself raises no request. These two sticky bits
  // are an addition for the system: bit 0 for each completion, bit 1 for
  // each abandoned conversion. Both reset masked, so irq stays low.
  wire [1:0] evSet = {abortCv, setDone};
  wire [1:0] evClr = (wrAccess && hitIrqStat && lane0) ? pwdata[1:0] : 2'h0;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irqStatus <= IRQ_RST;
      irqMask   <= IRQ_RST;
    end else begin
      irqStatus <= (irqStatus & ~evClr) | evSet;
      if (wrAccess && hitIrqMask && lane0) begin
        irqMask <= pwdata[1:0];
      end
    end
  end

  // System-level line; the converter itself raises no request R07
  assign irq = |(irqStatus & irqMask);

  // Read data mux
  // Unmapped addresses read as zero; pslverr flags them separately.
  // Every source is a flip-flop; the mux only selects by address.
  wire [7:0] ctrlView = {doneFlag, 1'b0, convOn, 1'b0, chanSel};
  always_comb begin
    prdata = 32'h0000_0000;
    if (hitResult) prdata = {24'h00_0000, result};      // R14
    if (hitCtrl)   prdata = {24'h00_0000, ctrlView};
    if (hitIrqStat) prdata = {30'h0000_0000, irqStatus};
    if (hitIrqMask) prdata = {30'h0000_0000, irqMask};
  end

  // Front end: capacitor connected only in load phase R04
  // A channel change always comes with a control write, which drops the
  // work in progress: a conversion never mixes two inputs.
  // The capacitor keeps its charge between conversions, which saves
  // current on the pin when a single channel is measured.
  always_comb begin
    afeCtrl.powerOn      = running;                     // R13
    afeCtrl.sampleSwitch = (phase == PH_LOAD);          // R04
    afeCtrl.channel      = chanSel;                     // R11
    afeCtrl.dacCode      = sarCode;
  end

  // Helper counting system clocks of one conversion
  // It clears on every completion, abort and stop, so it measures
  // exactly one uninterrupted conversion.
  logic [5:0] convClk;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      convClk <= 6'h00;
    end else if (phase == PH_OFF || ctrlWrite || sarEnd) begin
      convClk <= 6'h00;
    end else begin
      convClk <= convClk + 6'h01;
    end
  end

  // Comparator history of the running conversion, for the rail checks
  // A rail code needs every trial to agree, so one dissent is enough
  logic anyLow;   // Some trial answered below
  logic anyHigh;  // Some trial answered above
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      anyLow  <= 1'b0;
      anyHigh <= 1'b0;
    end else if (phase != PH_SAR) begin
      anyLow  <= 1'b0;
      anyHigh <= 1'b0;
    end else if (adcTick) begin
      anyLow  <= anyLow || !compareHigh;
      anyHigh <= anyHigh || compareHigh;
    end
  end

  // Assertions: every property is clocked by clk_sys and switched off
  // while reset is asserted. Rail checks use the comparator history
  // above rather than the datapath, so they do not restate it.
  chk_conv_length: assert property (@(posedge clk_sys) disable iff (!rst_b) // R05
    sarEnd |-> convClk >= 6'(CONV_PERIODS * CPU_PER_ADC - 2)
            && convClk <= 6'(CONV_PERIODS * CPU_PER_ADC - 1))
    else $error("conversion length wrong");
  chk_done_sets: assert property (@(posedge clk_sys) disable iff (!rst_b) // R07
    setDone |=> doneFlag)
    else $error("done flag not set");
  chk_done_clear: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
    (resultRead && !setDone) |=> !doneFlag)
    else $error("done flag not cleared by read");
  chk_result_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) // R08
    !$past(sarEnd) |-> $stable(result))
    else $error("result changed between conversions");
  chk_restart_load: assert property (@(posedge clk_sys) disable iff (!rst_b) // R09
    (restart && !haltMode) |=> phase == PH_LOAD && !doneFlag)
    else $error("control write did not restart");
  chk_off_stops: assert property (@(posedge clk_sys) disable iff (!rst_b) // R12
    (!convOn && !ctrlWrite) |=> phase == PH_OFF)
    else $error("converter ran while off");
  chk_halt_stops: assert property (@(posedge clk_sys) disable iff (!rst_b) // R13
    haltMode |-> !afeCtrl.powerOn ##1 phase == PH_OFF)
    else $error("converter ran in halt");
  chk_cap_isolated: assert property (@(posedge clk_sys) disable iff (!rst_b) // R04
    phase == PH_SAR |-> !afeCtrl.sampleSwitch)
    else $error("capacitor connected during approximation");
  chk_loop_back: assert property (@(posedge clk_sys) disable iff (!rst_b) // R03
    (sarEnd && running && !ctrlWrite) |=> phase == PH_LOAD)
    else $error("sequencer did not loop");
  chk_full_scale: assert property (@(posedge clk_sys) disable iff (!rst_b) // R01
    (sarEnd && !ctrlWrite && !anyLow && compareHigh) |=> result == CODE_FULL)
    else $error("full scale code wrong");
  chk_zero_scale: assert property (@(posedge clk_sys) disable iff (!rst_b) // R02
    (sarEnd && !ctrlWrite && !anyHigh && !compareHigh) |=> result == CODE_ZERO)
    else $error("zero scale code wrong");
  chk_tick_half: assert property (@(posedge clk_sys) disable iff (!rst_b) // R05
    (running && $past(running)) |-> (adcTick != $past(adcTick)))
    else $error("converter tick not at half rate");
  chk_chan_follow: assert property (@(posedge clk_sys) disable iff (!rst_b) // R11
    ctrlWrite |=> afeCtrl.channel == $past(pwdata[POS_CHAN +: CHAN_W]))
    else $error("channel not taken from control write");
  chk_wait_ignored: assert property (@(posedge clk_sys) disable iff (!rst_b) // R13
    (waitMode && convOn && !haltMode) |-> afeCtrl.powerOn)
    else $error("wait mode stopped the converter");
  chk_result_ro: assert property (@(posedge clk_sys) disable iff (!rst_b) // R14
    (wrAccess && hitResult && !sarEnd) |=> $stable(result))
    else $error("result changed by a bus write");

  // Covers for the main scenarios

  cov_conversion: cover property (@(posedge clk_sys) disable iff (!rst_b) setDone);
  cov_abort: cover property (@(posedge clk_sys) disable iff (!rst_b) phase == PH_SAR && ctrlWrite);
  cov_halt: cover property (@(posedge clk_sys) disable iff (!rst_b) convOn && haltMode);
  cov_read_done: cover property (@(posedge clk_sys) disable iff (!rst_b) resultRead && doneFlag);
  cov_full_scale: cover property (@(posedge clk_sys) disable iff (!rst_b) sarEnd && !anyLow && compareHigh);

endmodule

// *** core/adc_seq_pkg.sv ***
package adc_seq_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  IDX_RESULT     = 8'h70;
  localparam logic [7:0]  IDX_CTRL       = 8'h71;
  localparam logic [7:0]  IDX_IRQ_STATUS = 8'h72;
  localparam logic [7:0]  IDX_IRQ_MASK   = 8'h73;
  localparam logic [11:0] ADDR_RESULT     = {2'h0, IDX_RESULT, 2'h0};
  localparam logic [11:0] ADDR_CTRL       = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK   = {2'h0, IDX_IRQ_MASK, 2'h0};

  // Control/status field positions
  localparam int POS_DONE = 7;
  localparam int POS_ON   = 5;
  localparam int POS_CHAN = 0;
  localparam int CHAN_W   = 4;

  // Reset values
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [1:0] IRQ_RST    = 2'h0;

  // Event bits in the interrupt status and mask registers
  localparam int EV_DONE    = 0;
  localparam int EV_ABORTED = 1;

  // Conversion timing in converter clock periods
  localparam int CONV_PERIODS = 12;
  localparam int SAR_STEPS    = 8;
  localparam int LOAD_PERIODS = CONV_PERIODS - SAR_STEPS;
  localparam int CPU_PER_ADC  = 2;

  // Fixed result codes at the reference rails
  localparam logic [7:0] CODE_FULL = 8'hFF;
  localparam logic [7:0] CODE_ZERO = 8'h00;

  // Sequencer phases
  typedef enum logic [1:0] {
    PH_OFF  = 2'b00,
    PH_LOAD = 2'b01,
    PH_SAR  = 2'b10
  } phase_t;

  // Signals toward the analog front end, kept together
  typedef struct packed {
    logic       powerOn;
    logic       sampleSwitch;
    logic [3:0] channel;
    logic [7:0] dacCode;
  } afe_ctrl_t;

endpackage

// *** testbench/adc_front_end_model.sv ***
`timescale 1ns/100ps
module adc_front_end_model
  import adc_seq_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire afe_ctrl_t afeCtrl,
  output logic           compareHigh
);
  logic [7:0] pinLevel [16]; // Level on each pin, plain inputs set by the bench
  logic [7:0] heldLevel;     // Charge on the sample capacitor
  logic       junk = 1'b0;   // Meaningless output while unpowered

  // Capacitor tracks the chosen pin only while the switch is closed
  always_ff @(posedge clk_sys) begin
    if (afeCtrl.powerOn && afeCtrl.sampleSwitch) begin
      heldLevel <= pinLevel[afeCtrl.channel];
    end
  end

  // Unpowered comparator toggles so a stale answer never looks valid
  always @(posedge clk_sys) begin
    junk <= ~junk;
  end

  // Comparator: high when the held charge is at or above the trial code
  assign compareHigh = afeCtrl.powerOn ? (heldLevel >= afeCtrl.dacCode) : junk;
endmodule

// *** testbench/adc_sequencer_control_test.sv ***
`timescale 1ns/100ps
module adc_sequencer_control_test
  import adc_seq_pkg::*;
;
  logic        clk_sys = 1'b0;        // System clock
  logic        rst_b = 1'b0;          // Reset, active low
  logic        psel = 1'b0;           // APB request
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        haltMode = 1'b0;       // Power modes
  logic        waitMode = 1'b0;
  logic        compareHigh;           // From the front-end model
  afe_ctrl_t   afeCtrl;
  logic        irq;
  int          failCount = 0;         // Mismatches
  int          totalChecks = 0;       // Comparisons
  int          cycles = 0;            // Timeout counter
  logic [31:0] q;                     // Last read data
  logic        err;                   // Last error response
  int          hi;                    // Load phase length
  int          lo;                    // Approximation phase length
  logic [3:0]  chans [3] = '{4'h0, 4'hF, 4'h5};
  logic [7:0]  lvls [3] = '{8'hFF, 8'h00, 8'hA5};

  adc_sequencer_control u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .haltMode(haltMode), .waitMode(waitMode), .compareHigh(compareHigh),
    .afeCtrl(afeCtrl), .irq(irq));
  adc_front_end_model u_model (.clk_sys(clk_sys), .afeCtrl(afeCtrl), .compareHigh(compareHigh));

  // Clock at 100 MHz
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Cut a hang short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failCount++;
      endOfTest();
    end
  end

  task endOfTest();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; entered right after a rising edge, leaves one idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 8'h00);
    chk(what, q, exp);
  endtask

  // Poll the control byte until the done flag shows
  task automatic waitDone();
    q = 32'h0;
    for (int n = 0; n < 40 && q[POS_DONE] !== 1'b1; n++) begin
      apb(1'b0, ADDR_CTRL, 8'h00);
    end
    chk("done flag", {31'h0, q[POS_DONE]}, 32'h1);
  endtask

  // Count falling edges until the sample switch reaches a level
  task automatic waitLevel(input logic v, output int n);
    n = 0;
    while (afeCtrl.sampleSwitch !== v && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rdc(ADDR_RESULT, 32'h0, "result reset");
    rdc(ADDR_CTRL, 32'h0, "ctrl reset");
    apb(1'b0, 12'h1D0, 8'h00);
    chk("unmapped error", {31'h0, err}, 32'h1);
    apb(1'b1, ADDR_RESULT, 8'h55);
    chk("result write error", {31'h0, err}, 32'h1);
    rdc(ADDR_RESULT, 32'h0, "result unwritten");
    $display("test registers ended");
    for (int i = 0; i < 3; i++) begin
      u_model.pinLevel[chans[i]] = lvls[i];
      apb(1'b1, ADDR_CTRL, {4'h2, chans[i]});
      chk("channel", {28'h0, afeCtrl.channel}, {28'h0, chans[i]});
      waitDone();
      rdc(ADDR_RESULT, {24'h0, lvls[i]}, "result");
      rdc(ADDR_CTRL, {26'h0, 2'h2, chans[i]}, "done after read");
    end
    chk("irq masked", {31'h0, irq}, 32'h0);
    $display("test conversions ended");
    waitLevel(1'b0, hi);
    waitLevel(1'b1, hi);
    waitLevel(1'b0, hi);
    waitLevel(1'b1, lo);
    chk("load length", hi, LOAD_PERIODS * CPU_PER_ADC);
    chk("conversion length", hi + lo, CONV_PERIODS * CPU_PER_ADC);
    @(posedge clk_sys);
    waitDone();
    apb(1'b1, ADDR_CTRL, 8'h25);
    rdc(ADDR_CTRL, 32'h25, "done after write");
    $display("test timing ended");
    haltMode <= 1'b1;
    waitMode <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("halt power", {31'h0, afeCtrl.powerOn}, 32'h0);
    haltMode <= 1'b0;
    @(posedge clk_sys);
    waitDone();
    apb(1'b1, ADDR_CTRL, 8'h05);
    u_model.pinLevel[5] = 8'h77;
    repeat (60) @(posedge clk_sys);
    chk("off power", {31'h0, afeCtrl.powerOn}, 32'h0);
    rdc(ADDR_CTRL, 32'h05, "off ctrl");
    rdc(ADDR_RESULT, 32'hA5, "result kept");
    $display("test power ended");
    apb(1'b1, ADDR_IRQ_MASK, 8'h01);
    chk("irq raised", {31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_IRQ_STATUS, 8'h01);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b0, ADDR_IRQ_STATUS, 8'h00);
    chk("status bits", q, 32'h2);
    $display("test interrupt ended");
    endOfTest();
  end
endmodule
